// file: pkg/desi_pkg.sv
// constants and types for the dma event select and interrupt aggregation block
// How it works
// RQ1 - four controllers of four channels each, one event output per channel
// RQ2 - one completion pulse input per channel drives the flag logic
// RQ3 - twenty event sources, each channel selects independently
// RQ4 - each channel's event is chosen by a software event code field
// RQ5 - code 0000b gives the channel no event
// RQ6 - controllers 0..2: codes 1,2 route audio 0, audio 2, two-wire tx/rx
// RQ7 - controller 3: codes 1,2 route audio 1 tx/rx; 3..11 reserved
// RQ8 - controller 2: code 3 converter, codes 4,5 audio 3 tx/rx
// RQ9 - controller 0 codes 5..8 card 0/1 tx/rx; controller 1 codes 5,6 uart
// RQ10 - codes 12..14 route timers 0..2 for all; code 15 reserved
// RQ11 - flag and enable registers combine completions into one cpu interrupt
// RQ12 - two event select registers per controller at the mapped addresses
// RQ13 - channel codes in bits 3-0 and 11-8, other bits read zero
// RQ14 - flag bit 4n+m sets on completion, cleared by writing one
// RQ15 - enable bit gates each channel onto the interrupt, enables reset zero
// RQ16 - several channels may select one event at once, all receive it
// RQ17 - interrupt is or of each flag anded with its enable, held until cleared
package desi_pkg;
  localparam int NUM_CTRL = 4;
  localparam int NUM_CH = 4;
  localparam int NUM_SRC = 20;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SEL0_LO = 16'h1c1a;
  localparam logic [15:0] IDX_SEL0_HI = 16'h1c1b;
  localparam logic [15:0] IDX_SEL1_LO = 16'h1c1c;
  localparam logic [15:0] IDX_SEL1_HI = 16'h1c1d;
  localparam logic [15:0] IDX_FLAGS = 16'h1c30;
  localparam logic [15:0] IDX_ENABLES = 16'h1c31;
  localparam logic [15:0] IDX_SEL2_LO = 16'h1c36;
  localparam logic [15:0] IDX_SEL2_HI = 16'h1c37;
  localparam logic [15:0] IDX_SEL3_LO = 16'h1c38;
  localparam logic [15:0] IDX_SEL3_HI = 16'h1c39;
  localparam int CODE_LO_POS = 0;
  localparam int CODE_HI_POS = 8;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // event source indices on the evt_src_i vector
  localparam int SRC_AUD0_TX = 0;
  localparam int SRC_AUD0_RX = 1;
  localparam int SRC_AUD1_TX = 2;
  localparam int SRC_AUD1_RX = 3;
  localparam int SRC_AUD2_TX = 4;
  localparam int SRC_AUD2_RX = 5;
  localparam int SRC_AUD3_TX = 6;
  localparam int SRC_AUD3_RX = 7;
  localparam int SRC_TWI_TX = 8;
  localparam int SRC_TWI_RX = 9;
  localparam int SRC_UART_TX = 10;
  localparam int SRC_UART_RX = 11;
  localparam int SRC_CARD0_TX = 12;
  localparam int SRC_CARD0_RX = 13;
  localparam int SRC_CARD1_TX = 14;
  localparam int SRC_CARD1_RX = 15;
  localparam int SRC_CONV = 16;
  localparam int SRC_TMR0 = 17;
  localparam int SRC_TMR1 = 18;
  localparam int SRC_TMR2 = 19;
  typedef struct packed {
    logic [31:0] addr;
    logic valid;
  } desi_addr_t;
endpackage

// file: rtl/desi_top.sv
// event selection and completion interrupt aggregation for four dma units
`timescale 1ns/1ps
`default_nettype none
module desi_top
  import desi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // axi4-lite write address and data
  input wire logic [31:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read
  input wire logic [31:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // peripheral events and channel completions, same clock domain
  input wire logic [NUM_SRC-1:0] evt_src_i,
  input wire logic [NUM_CTRL*NUM_CH-1:0] channel_done_i,
  // per-channel sync events and cpu interrupt
  output logic [NUM_CTRL*NUM_CH-1:0] channel_event_o,
  output logic dma_irq_o
);

  localparam int NCH = NUM_CTRL * NUM_CH;

  // write channel capture: address and data may arrive in either order
  desi_addr_t aw_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic wd_valid_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] ar_addr_reg;

  logic [3:0] code_reg [NCH];
  logic [15:0] dma_irq_flags_reg;
  logic [15:0] dma_irq_enables_reg;
  logic [NCH-1:0] channel_event_reg;

  wire aw_hs = s_awvalid_i && s_awready_o;
  wire w_hs = s_wvalid_i && s_wready_o;
  assign s_awready_o = !aw_reg.valid && !bvalid_reg;
  assign s_wready_o = !wd_valid_reg && !bvalid_reg;
  wire do_write = aw_reg.valid && wd_valid_reg && !bvalid_reg;
  // only the low halfword carries register bits
  wire lo_en = ws_reg[0];
  wire hi_en = ws_reg[1];
  wire [15:0] wr_idx = aw_reg.addr[17:2];
  wire wr_aligned = aw_reg.addr[1:0] == 2'b00 && aw_reg.addr[31:18] == '0;
  wire [15:0] rd_idx = ar_addr_reg[17:2];
  wire rd_aligned = ar_addr_reg[1:0] == 2'b00 && ar_addr_reg[31:18] == '0;

  // RQ12 register map decode
  // index to controller/half decode for the event select registers
  function automatic logic [3:0] sel_decode(input logic [15:0] idx);
    logic [3:0] r;
    r = 4'h0;
    case (idx)
      IDX_SEL0_LO: r = 4'b1_000;
      IDX_SEL0_HI: r = 4'b1_001;
      IDX_SEL1_LO: r = 4'b1_010;
      IDX_SEL1_HI: r = 4'b1_011;
      IDX_SEL2_LO: r = 4'b1_100;
      IDX_SEL2_HI: r = 4'b1_101;
      IDX_SEL3_LO: r = 4'b1_110;
      IDX_SEL3_HI: r = 4'b1_111;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  wire [3:0] wr_sel = sel_decode(wr_idx);
  wire [3:0] rd_sel = sel_decode(rd_idx);
  wire wr_flags = wr_aligned && wr_idx == IDX_FLAGS;
  wire wr_enables = wr_aligned && wr_idx == IDX_ENABLES;
  wire wr_sel_hit = wr_aligned && wr_sel[3];
  wire wr_hit = wr_flags || wr_enables || wr_sel_hit;
  wire rd_hit = rd_aligned && (rd_sel[3] || rd_idx == IDX_FLAGS ||
                               rd_idx == IDX_ENABLES);

  // base channel of the selected register: 4*ctrl + 2*half
  wire [3:0] wr_base = {wr_sel[2:1], wr_sel[0], 1'b0};
  wire [3:0] rd_base = {rd_sel[2:1], rd_sel[0], 1'b0};

  // RQ13 field packing; reserved bits read zero
  wire [15:0] sel_rdata = {4'h0, code_reg[rd_base + 4'd1], 4'h0,
                           code_reg[rd_base]};
  wire [15:0] rd_word = rd_sel[3] ? sel_rdata :
                        (rd_idx == IDX_FLAGS) ? dma_irq_flags_reg :
                        dma_irq_enables_reg;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_reg <= '0;
      wd_valid_reg <= 1'b0;
      wd_reg <= '0;
      ws_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_reg <= '{addr: s_awaddr_i, valid: 1'b1};
      end
      if (w_hs) begin
        wd_reg <= s_wdata_i;
        ws_reg <= s_wstrb_i;
        wd_valid_reg <= 1'b1;
      end
      if (do_write) begin
        aw_reg.valid <= 1'b0;
        wd_valid_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_bvalid_o = bvalid_reg;
  assign s_bresp_o = bresp_reg;

  // read path: one cycle from address accept to rvalid
  assign s_arready_o = !arvalid_reg && !rvalid_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arvalid_reg <= 1'b0;
      ar_addr_reg <= '0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (s_arvalid_i && s_arready_o) begin
        arvalid_reg <= 1'b1;
        ar_addr_reg <= s_araddr_i;
      end else if (arvalid_reg) begin
        arvalid_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_hit ? {16'h0000, rd_word} : 32'h0000_0000;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_rvalid_o = rvalid_reg;
  assign s_rdata_o = rdata_reg;
  assign s_rresp_o = rresp_reg;

  // per-channel code storage and event routing
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam int CTRL = g / NUM_CH;
      localparam logic [3:0] BASE = 4'((g / 2) * 2);
      localparam bit IS_HI_FIELD = (g % 2) == 1;
      wire lane_en = IS_HI_FIELD ? hi_en : lo_en;
      wire [3:0] wdata_code = IS_HI_FIELD ? wd_reg[CODE_HI_POS +: 4] :
                                            wd_reg[CODE_LO_POS +: 4];
      // RQ4 code write
      wire code_we = do_write && wr_sel_hit && wr_base == BASE && lane_en;
      wire [3:0] code = code_reg[g];
      logic sel_evt;

      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          code_reg[g] <= CODE_RESET;
        end else if (code_we) begin
          code_reg[g] <= wdata_code;
        end
      end

      // RQ3 independent selector per channel, RQ16 sources fan out freely
      always_comb begin
        sel_evt = 1'b0;
        case (code)
          // RQ5 no event
          4'h0: sel_evt = 1'b0;
          // RQ6 RQ7 codes one and two
          4'h1: sel_evt = CTRL == 0 ? evt_src_i[SRC_AUD0_TX] :
                          CTRL == 1 ? evt_src_i[SRC_AUD2_TX] :
                          CTRL == 2 ? evt_src_i[SRC_TWI_TX] :
                                      evt_src_i[SRC_AUD1_TX];
          4'h2: sel_evt = CTRL == 0 ? evt_src_i[SRC_AUD0_RX] :
                          CTRL == 1 ? evt_src_i[SRC_AUD2_RX] :
                          CTRL == 2 ? evt_src_i[SRC_TWI_RX] :
                                      evt_src_i[SRC_AUD1_RX];
          // RQ8 converter and audio port 3
          4'h3: sel_evt = CTRL == 2 && evt_src_i[SRC_CONV];
          4'h4: sel_evt = CTRL == 2 && evt_src_i[SRC_AUD3_TX];
          // RQ9 card and uart, plus RQ8 audio 3 receive on code 5
          4'h5: sel_evt = CTRL == 0 ? evt_src_i[SRC_CARD0_TX] :
                          CTRL == 1 ? evt_src_i[SRC_UART_TX] :
                          CTRL == 2 ? evt_src_i[SRC_AUD3_RX] : 1'b0;
          4'h6: sel_evt = CTRL == 0 ? evt_src_i[SRC_CARD0_RX] :
                          CTRL == 1 ? evt_src_i[SRC_UART_RX] : 1'b0;
          4'h7: sel_evt = CTRL == 0 && evt_src_i[SRC_CARD1_TX];
          4'h8: sel_evt = CTRL == 0 && evt_src_i[SRC_CARD1_RX];
          // RQ10 timers for every controller
          4'hc: sel_evt = evt_src_i[SRC_TMR0];
          4'hd: sel_evt = evt_src_i[SRC_TMR1];
          4'he: sel_evt = evt_src_i[SRC_TMR2];
          default: sel_evt = 1'b0;
        endcase
      end

      // RQ1 registered event output per channel
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          channel_event_reg[g] <= 1'b0;
        end else begin
          channel_event_reg[g] <= sel_evt;
        end
      end
    end
  endgenerate

  assign channel_event_o = channel_event_reg;

  // RQ14 set wins over a simultaneous write-one clear
  wire [15:0] flag_clr = (do_write && wr_flags && lo_en && hi_en) ?
                         wd_reg[15:0] :
                         (do_write && wr_flags) ?
                         {hi_en ? wd_reg[15:8] : 8'h00,
                          lo_en ? wd_reg[7:0] : 8'h00} : 16'h0000;
  // RQ2 completions feed the flags
  wire [15:0] flags_next = (dma_irq_flags_reg & ~flag_clr) | channel_done_i;
  wire [15:0] enables_next = {hi_en ? wd_reg[15:8] : dma_irq_enables_reg[15:8],
                              lo_en ? wd_reg[7:0] : dma_irq_enables_reg[7:0]};

  // RQ11 RQ15 flag and enable registers, enables reset to zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_irq_flags_reg <= IRQ_RESET;
      dma_irq_enables_reg <= IRQ_RESET;
    end else begin
      dma_irq_flags_reg <= flags_next;
      if (do_write && wr_enables) begin
        dma_irq_enables_reg <= enables_next;
      end
    end
  end

  // RQ17 level interrupt while any enabled flag is set
  assign dma_irq_o = |(dma_irq_flags_reg & dma_irq_enables_reg);

  // RQ14 completion sets flag
  a_flag_sets: assert property ( // RQ14
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    channel_done_i[0] |=> dma_irq_flags_reg[0])
    else $error("completion did not set its flag");

  // RQ14 flag stays set
  a_flag_holds: assert property ( // RQ14
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    dma_irq_flags_reg[3] && !(do_write && wr_flags && lo_en && wd_reg[3])
    |=> dma_irq_flags_reg[3])
    else $error("flag dropped without a clear");

  // RQ14 write one clears
  a_flag_clears: assert property ( // RQ14
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    do_write && wr_flags && lo_en && wd_reg[6] && !channel_done_i[6]
    |=> !dma_irq_flags_reg[6])
    else $error("write of one did not clear the flag");

  // RQ14 set beats clear
  a_set_wins: assert property ( // RQ14
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    do_write && wr_flags && channel_done_i[10] |=> dma_irq_flags_reg[10])
    else $error("clear in the same cycle lost a completion");

  // RQ17 enabled flag raises irq
  a_irq_gate: assert property ( // RQ17
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (dma_irq_flags_reg[5] && dma_irq_enables_reg[5]) |-> dma_irq_o)
    else $error("enabled flag did not raise the interrupt");

  // RQ15 masked irq low
  a_irq_masked: assert property ( // RQ15
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (dma_irq_enables_reg == 16'h0000) |-> !dma_irq_o)
    else $error("interrupt raised with all enables off");

  // RQ10 timer routing
  a_timer_route: assert property ( // RQ10
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[9] == 4'hc && evt_src_i[SRC_TMR0]) |=> channel_event_o[9])
    else $error("timer 0 not routed");

  // RQ10 code fifteen reserved
  a_code15_resv: assert property ( // RQ10
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[0] == 4'hf) |=> !channel_event_o[0])
    else $error("reserved code fifteen produced an event");

  // RQ5 code zero silent
  a_null_code: assert property ( // RQ5
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[2] == 4'h0) |=> !channel_event_o[2])
    else $error("code zero produced an event");

  // RQ7 controller 3 reserved
  a_ctrl3_resv: assert property ( // RQ7
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[12] == 4'h5) |=> !channel_event_o[12])
    else $error("reserved code on controller 3 produced an event");

  // RQ8 converter routing
  a_conv_route: assert property ( // RQ8
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[8] == 4'h3 && evt_src_i[SRC_CONV]) |=> channel_event_o[8])
    else $error("converter event not routed");

  // RQ9 uart receive routing
  a_uart_route: assert property ( // RQ9
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[4] == 4'h6)
    |=> channel_event_o[4] == $past(evt_src_i[SRC_UART_RX]))
    else $error("uart receive not routed");

  // RQ16 shared event fan-out
  a_shared_route: assert property ( // RQ16
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (code_reg[1] == 4'hc && code_reg[13] == 4'hc && evt_src_i[SRC_TMR0])
    |=> channel_event_o[1] && channel_event_o[13])
    else $error("shared event not delivered to both channels");

endmodule
`default_nettype wire

// file: testbench/desi_dma_model.sv
// far-side model: peripheral event sources and dma channel completions
`timescale 1ns/1ps
`default_nettype none
module desi_dma_model
  import desi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bench requests
  input wire logic [NUM_SRC-1:0] evt_req_i,
  input wire logic [NUM_CTRL*NUM_CH-1:0] done_req_i,
  // towards the block
  output logic [NUM_SRC-1:0] evt_src_o,
  output logic [NUM_CTRL*NUM_CH-1:0] channel_done_o
);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_src_o <= '0;
      channel_done_o <= '0;
    end else begin
      evt_src_o <= evt_req_i;
      channel_done_o <= done_req_i;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for event select and interrupt aggregation
`timescale 1ns/1ps
`default_nettype none
module tb
  import desi_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] aw = '0, wd = '0, ar = '0, rd;
  logic [3:0] ws = '0;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awr, wr, bv, arr, rv, irq;
  logic [1:0] br, rr;
  logic [19:0] ev_req = '0, evt;
  logic [15:0] dn_req = '0, dn, ch_ev;
  int err_count = 0, total_checks = 0, cycles = 0;
  logic [31:0] got, exp_ev;
  localparam logic [15:0] REGS [10] = '{IDX_SEL0_LO, IDX_SEL0_HI,
    IDX_SEL1_LO, IDX_SEL1_HI, IDX_FLAGS, IDX_ENABLES, IDX_SEL2_LO,
    IDX_SEL2_HI, IDX_SEL3_LO, IDX_SEL3_HI};
  desi_top u_desi_top (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .s_awaddr_i(aw), .s_awvalid_i(awv), .s_awready_o(awr),
    .s_wdata_i(wd), .s_wstrb_i(ws), .s_wvalid_i(wv), .s_wready_o(wr),
    .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bre),
    .s_araddr_i(ar), .s_arvalid_i(arv), .s_arready_o(arr),
    .s_rdata_o(rd), .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rre),
    .evt_src_i(evt), .channel_done_i(dn), .channel_event_o(ch_ev),
    .dma_irq_o(irq));
  desi_dma_model u_desi_dma_model (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .evt_req_i(ev_req), .done_req_i(dn_req),
    .evt_src_o(evt), .channel_done_o(dn));
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    // hang guard, far above the expected run length
    if (cycles == 50000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // unmapped indices answer with an error response
  function automatic logic [31:0] exp_resp(logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 10; i++) hit |= REGS[i] == idx;
    return {30'h0, hit ? RESP_OKAY : RESP_SLVERR};
  endfunction
  task automatic wr_reg(logic [15:0] idx, logic [31:0] d,
                        logic [3:0] s = 4'hf);
    logic a, w, b;
    a = 0;
    w = 0;
    b = 0;
    @(posedge sys_clk_i);
    aw <= {14'h0, idx, 2'b00};
    wd <= d;
    ws <= s;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!b) begin
      @(posedge sys_clk_i);
      if (!a && awr) begin
        a = 1;
        awv <= 0;
      end
      if (!w && wr) begin
        w = 1;
        wv <= 0;
      end
      if (bv) begin
        b = 1;
        bre <= 0;
        check("bresp", {30'h0, br}, exp_resp(idx));
      end
    end
    #1;
  endtask
  task automatic rd_reg(logic [15:0] idx, logic [31:0] exp);
    logic a;
    a = 0;
    @(posedge sys_clk_i);
    ar <= {14'h0, idx, 2'b00};
    arv <= 1;
    rre <= 1;
    while (!a || !rv) begin
      @(posedge sys_clk_i);
      if (!a && arr) begin
        a = 1;
        arv <= 0;
      end
    end
    rre <= 0;
    check("rdata", rd, exp);
    check("rresp", {30'h0, rr}, exp_resp(idx));
  endtask
  task automatic pulse(logic [15:0] m);
    @(posedge sys_clk_i);
    dn_req <= m;
    @(posedge sys_clk_i);
    dn_req <= '0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  function automatic logic [15:0] sel_idx(int c, int h);
    logic [15:0] base [4] = '{IDX_SEL0_LO, IDX_SEL1_LO, IDX_SEL2_LO,
      IDX_SEL3_LO};
    return base[c] + 16'(h);
  endfunction
  // expected source for a code, -1 where no event is routed
  function automatic int exp_src(int c, int k);
    if (k >= 12 && k <= 14) return SRC_TMR0 + k - 12;
    case ({c[1:0], k[3:0]})
      6'h01: return SRC_AUD0_TX;
      6'h02: return SRC_AUD0_RX;
      6'h05: return SRC_CARD0_TX;
      6'h06: return SRC_CARD0_RX;
      6'h07: return SRC_CARD1_TX;
      6'h08: return SRC_CARD1_RX;
      6'h11: return SRC_AUD2_TX;
      6'h12: return SRC_AUD2_RX;
      6'h15: return SRC_UART_TX;
      6'h16: return SRC_UART_RX;
      6'h21: return SRC_TWI_TX;
      6'h22: return SRC_TWI_RX;
      6'h23: return SRC_CONV;
      6'h24: return SRC_AUD3_TX;
      6'h25: return SRC_AUD3_RX;
      6'h31: return SRC_AUD1_TX;
      6'h32: return SRC_AUD1_RX;
      default: return -1;
    endcase
  endfunction
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 10; i++) rd_reg(REGS[i], 32'h0);
    rd_reg(16'h1c00, 32'h0);
    wr_reg(16'h1c00, 32'hffff);
    // reserved bits are written as ones and must read back zero
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 16; k++) begin
        wr_reg(sel_idx(c, 0), 32'hfff0f0f0 | 32'(k * 257));
        wr_reg(sel_idx(c, 1), 32'h0000f0f0 | 32'(k));
        rd_reg(sel_idx(c, 0), 32'(k * 257));
        rd_reg(sel_idx(c, 1), 32'(k));
        for (int s = 0; s < 20; s++) begin
          @(posedge sys_clk_i);
          ev_req <= 20'h1 << s;
          repeat (3) @(posedge sys_clk_i);
          #1;
          exp_ev = exp_src(c, k) == s ? 32'h7 : 32'h0;
          got = 32'(ch_ev[4*c+:4]);
          check("event", got, exp_ev);
        end
      end
    end
    for (int c = 0; c < 4; c++) begin
      wr_reg(sel_idx(c, 0), 32'h0c0c);
      wr_reg(sel_idx(c, 1), 32'h0c0c);
    end
    @(posedge sys_clk_i);
    ev_req <= 20'h1 << SRC_TMR0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("shared event", 32'(ch_ev), 32'hffff);
    pulse(16'h0200);
    rd_reg(IDX_FLAGS, 32'h0200);
    check("irq masked", 32'(irq), 32'h0);
    pulse(16'hffff);
    rd_reg(IDX_FLAGS, 32'hffff);
    wr_reg(IDX_ENABLES, 32'h0020);
    check("irq one", 32'(irq), 32'h1);
    wr_reg(IDX_FLAGS, 32'h0020);
    check("irq cleared", 32'(irq), 32'h0);
    rd_reg(IDX_FLAGS, 32'hffdf);
    wr_reg(IDX_ENABLES, 32'hffff);
    rd_reg(IDX_ENABLES, 32'hffff);
    // upper byte lane only: enables 15..8 cleared, 7..0 kept
    wr_reg(IDX_ENABLES, 32'h0, 4'h2);
    rd_reg(IDX_ENABLES, 32'h00ff);
    wr_reg(IDX_FLAGS, 32'hff00);
    check("irq held", 32'(irq), 32'h1);
    wr_reg(IDX_FLAGS, 32'h00ff);
    check("irq off", 32'(irq), 32'h0);
    rd_reg(IDX_FLAGS, 32'h0);
    // completion lands on the same edge as the write-one clear
    fork
      wr_reg(IDX_FLAGS, 32'h0400);
      pulse(16'h0400);
    join
    rd_reg(IDX_FLAGS, 32'h0400);
    check("irq gated", 32'(irq), 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
